// ==== verilog/swf_pkg.sv ====
// Constants, enums and state structs for the supervisory watchdog
// Notes on behaviour
// RQ1 - Reset held while monitor is low, then held one hold period after it rises
// RQ2 - Timeout variant: a full period without a kick asserts reset for hold period
// RQ3 - Watchdog timer cleared on reset assertion and on every accepted kick edge
// RQ4 - Timer stays zero while reset is asserted, counts from zero after release
// RQ5 - Kick falling edges are ignored while reset output is low
// RQ6 - Windowed: kick inside the closed window is early and asserts reset
// RQ7 - Windowed: kick inside the open window is good and restarts the timer
// RQ8 - Open window is one half or three quarters of the period
// RQ9 - Kick on the window boundary may count as either good or early
// RQ10 - Failover asserts after three consecutive periods with no kick
// RQ11 - Failover releases after three consecutive good kicks within a period
// RQ12 - Windowed: three bad kicks assert failover, three good ones release it
// RQ13 - Failover never asserts while the monitor input (enable input in gated variant) is low
// RQ14 - Gated variant: watchdog runs only while enable input is high
// RQ15 - Gated variant: each enable rise makes the first period eight times long
// RQ16 - A kick during the extended period switches to the normal period
// RQ17 - No kick in the extended period asserts failover; next kick restores normal
// RQ18 - At power-up the hold timer starts only once the monitor input is high
// RQ19 - Processor must kick within every period, or only in the open window
// RQ20 - Periods and variant are parameters counted in device clock cycles
// RQ21 - Outputs active low; kick input synchronised before edge detection
package swf_pkg;

  // Watchdog flavours
  typedef enum logic [1:0] {
    SWF_TIMEOUT,
    SWF_WINDOWED,
    SWF_GATED
  } swf_variant_e;

  // Counter width shared by all period counters
  localparam int CNT_W = 32;
  // Default watchdog period in clock cycles
  localparam int WDOG_PERIOD_DEF = 1000;
  // Default reset hold period in clock cycles
  localparam int RESET_HOLD_DEF = 200;
  // Stretch of the first period after enable rises
  localparam int EXT_FACTOR = 8;
  // Open window expressed in quarters of the period
  localparam int OPEN_QUARTERS_DEF = 2;
  localparam int QUARTERS = 4;
  // Consecutive events that switch the failover flag
  localparam logic [1:0] EVENT_RUN = 2'h3;

  // Kick synchroniser state
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } swf_kick_s;

  localparam swf_kick_s KICK_RESET = '{meta: 1'b1, sync: 1'b1, last: 1'b1};

  // Supervisor state
  typedef struct packed {
    logic rst_n;
    logic fail_n;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] wd_cnt;
    logic extended;
    logic [1:0] bad_cnt;
    logic [1:0] good_cnt;
    logic en_last;
  } swf_state_s;

  localparam swf_state_s STATE_RESET = '{
    rst_n: 1'b0,
    fail_n: 1'b1,
    hold_cnt: '0,
    wd_cnt: '0,
    extended: 1'b0,
    bad_cnt: 2'h0,
    good_cnt: 2'h0,
    en_last: 1'b0
  };

endpackage

// ==== verilog/swf_kick_sync.sv ====
// Kick input synchroniser with falling-edge detection
`timescale 1ns/1ps
module swf_kick_sync (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic kick_in,
  output logic fall_out
);

  swf_pkg::swf_kick_s st_ff;
  swf_pkg::swf_kick_s nxt_st;

  // Two-flop synchroniser then edge memory
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = kick_in;
    nxt_st.sync = st_ff.meta;
    nxt_st.last = st_ff.sync;
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_ff <= swf_pkg::KICK_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Falling edge after synchronisation
  assign fall_out = st_ff.last & ~st_ff.sync; // RQ21

endmodule // swf_kick_sync

// ==== verilog/swf_top.sv ====
// Supervisory watchdog with reset hold and failover flag
`timescale 1ns/1ps
module swf_top #(
  parameter swf_pkg::swf_variant_e VARIANT = swf_pkg::SWF_TIMEOUT,
  parameter int WDOG_PERIOD_CYC = swf_pkg::WDOG_PERIOD_DEF,
  parameter int RESET_HOLD_CYC = swf_pkg::RESET_HOLD_DEF,
  parameter int OPEN_QUARTERS = swf_pkg::OPEN_QUARTERS_DEF
) (
  input wire logic MCLK_IN,
  input wire logic RSTN_IN,
  input wire logic KICK_IN,
  input wire logic MONITOR_ABOVE_IN,
  input wire logic ENABLE_CMP_IN,
  output logic RESET_N_OUT,
  output logic FAILOVER_N_OUT
);

  localparam int CW = swf_pkg::CNT_W;
  // Period lengths in cycles
  localparam logic [CW-1:0] PERIOD = CW'(WDOG_PERIOD_CYC); // RQ20
  localparam logic [CW-1:0] EXT_PERIOD =
    CW'(WDOG_PERIOD_CYC * swf_pkg::EXT_FACTOR); // RQ15
  localparam logic [CW-1:0] HOLD_LAST = CW'(RESET_HOLD_CYC - 1); // RQ20
  // Open window is a fixed fraction; the rest is closed
  localparam logic [CW-1:0] OPEN_LEN =
    CW'((WDOG_PERIOD_CYC * OPEN_QUARTERS) / swf_pkg::QUARTERS); // RQ8
  localparam logic [CW-1:0] CLOSED_LEN = PERIOD - OPEN_LEN; // RQ8
  localparam bit IS_GATED = (VARIANT == swf_pkg::SWF_GATED);
  localparam bit IS_WINDOW = (VARIANT == swf_pkg::SWF_WINDOWED);

  swf_pkg::swf_state_s st_ff;
  swf_pkg::swf_state_s nxt_st;

  logic kick_fall;
  logic mon_ok;
  logic running;
  logic kick_ok;
  logic early_ev;
  logic good_ev;
  logic late_ev;
  logic bad_ev;
  logic en_rise;
  logic [CW-1:0] limit_last;

  // Kick pin synchronised and edge detected
  swf_kick_sync u_kick_sync (
    .clk_in(MCLK_IN),
    .rstn_in(RSTN_IN),
    .kick_in(KICK_IN),
    .fall_out(kick_fall)
  );

  // Supervising comparator depends on variant
  assign mon_ok = IS_GATED ? ENABLE_CMP_IN : MONITOR_ABOVE_IN;
  // Watchdog runs only with enable high or reset released
  assign running = IS_GATED ? ENABLE_CMP_IN : st_ff.rst_n; // RQ14 RQ4
  // Edges while reset is low do not count
  assign kick_ok = kick_fall & running; // RQ5
  assign en_rise = IS_GATED & ENABLE_CMP_IN & ~st_ff.en_last; // RQ15
  // Last count of the current period
  assign limit_last = (st_ff.extended ? EXT_PERIOD : PERIOD) - CW'(1);

  // Event classification; boundary cycle counts as good
  assign early_ev = IS_WINDOW & kick_ok & ~en_rise
    & (st_ff.wd_cnt < CLOSED_LEN); // RQ6 RQ9
  assign good_ev = kick_ok & ~en_rise & ~early_ev; // RQ7
  assign late_ev = running & ~kick_ok & ~en_rise
    & (st_ff.wd_cnt == limit_last); // RQ2
  assign bad_ev = early_ev | late_ev; // RQ12

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.en_last = ENABLE_CMP_IN;

    // Watchdog timer
    if (!running) begin
      nxt_st.wd_cnt = '0; // RQ4 RQ3
    end else if (en_rise) begin
      nxt_st.wd_cnt = '0;
      nxt_st.extended = 1'b1; // RQ15
    end else if (kick_ok) begin
      nxt_st.wd_cnt = '0; // RQ3 RQ7
      nxt_st.extended = 1'b0; // RQ16 RQ17
    end else if (late_ev) begin
      nxt_st.wd_cnt = '0;
    end else begin
      nxt_st.wd_cnt = st_ff.wd_cnt + CW'(1);
    end

    // Reset output with hold period
    if (IS_GATED) begin
      nxt_st.rst_n = 1'b1;
      nxt_st.hold_cnt = '0;
    end else if (!mon_ok) begin
      nxt_st.rst_n = 1'b0; // RQ1 RQ18
      nxt_st.hold_cnt = '0;
    end else if (bad_ev) begin
      nxt_st.rst_n = 1'b0; // RQ2 RQ6
      nxt_st.hold_cnt = '0;
      nxt_st.wd_cnt = '0; // RQ3
    end else if (!st_ff.rst_n) begin
      if (st_ff.hold_cnt >= HOLD_LAST) begin
        nxt_st.rst_n = 1'b1; // RQ1 RQ18
        nxt_st.hold_cnt = '0;
      end else begin
        nxt_st.hold_cnt = st_ff.hold_cnt + CW'(1);
      end
    end

    // Failover flag driven by runs of events
    if (!mon_ok) begin
      nxt_st.fail_n = 1'b1; // RQ13
      nxt_st.bad_cnt = 2'h0;
      nxt_st.good_cnt = 2'h0;
    end else if (bad_ev) begin
      nxt_st.good_cnt = 2'h0;
      if (st_ff.bad_cnt != swf_pkg::EVENT_RUN) begin
        nxt_st.bad_cnt = st_ff.bad_cnt + 2'h1;
      end
      if (st_ff.bad_cnt >= swf_pkg::EVENT_RUN - 2'h1) begin
        nxt_st.fail_n = 1'b0; // RQ10 RQ12
      end
      if (late_ev && st_ff.extended) begin
        nxt_st.fail_n = 1'b0; // RQ17
      end
    end else if (good_ev) begin
      nxt_st.bad_cnt = 2'h0;
      if (st_ff.good_cnt >= swf_pkg::EVENT_RUN - 2'h1) begin
        nxt_st.fail_n = 1'b1; // RQ11 RQ12
        nxt_st.good_cnt = 2'h0;
      end else begin
        nxt_st.good_cnt = st_ff.good_cnt + 2'h1;
      end
    end
  end

  // State register
  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      st_ff <= swf_pkg::STATE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flops
  assign RESET_N_OUT = st_ff.rst_n; // RQ21
  assign FAILOVER_N_OUT = st_ff.fail_n; // RQ21

  // Checks on the supervisor
  default clocking swf_cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RSTN_IN);

  // Reset follows a low monitor
  chk_mon_low_reset: assert property ( // RQ1
    !IS_GATED && !MONITOR_ABOVE_IN |=> !RESET_N_OUT)
    else $error("reset not asserted with monitor low");

  // Release only after a full hold
  chk_hold_length: assert property ( // RQ18
    !IS_GATED && $rose(RESET_N_OUT) |-> $past(st_ff.hold_cnt) == HOLD_LAST
      && $past(MONITOR_ABOVE_IN))
    else $error("reset released before hold period");

  // Late fault forces reset
  chk_late_reset: assert property ( // RQ2
    !IS_GATED && late_ev |=> !RESET_N_OUT && st_ff.hold_cnt == '0)
    else $error("late fault without reset");

  // Timer frozen at zero under reset
  chk_timer_held: assert property ( // RQ4
    !IS_GATED && !RESET_N_OUT |=> st_ff.wd_cnt == '0)
    else $error("timer runs during reset");

  // Kicks ignored in reset
  chk_kick_ignored: assert property ( // RQ5
    !IS_GATED && !RESET_N_OUT |-> !good_ev && !early_ev)
    else $error("kick counted during reset");

  // Early kick forces reset
  chk_early_reset: assert property ( // RQ6
    early_ev && !IS_GATED |=> !RESET_N_OUT)
    else $error("early kick without reset");

  // Good kick restarts timer, reset stays high
  chk_good_restart: assert property ( // RQ7
    good_ev && RESET_N_OUT && mon_ok |=> RESET_N_OUT && st_ff.wd_cnt == '0)
    else $error("good kick mishandled");

  // Open window kicks never early
  chk_open_window: assert property ( // RQ8
    kick_ok && st_ff.wd_cnt >= CLOSED_LEN |-> !early_ev)
    else $error("open window kick flagged early");

  // Third bad event asserts failover
  chk_fail_assert: assert property ( // RQ10
    bad_ev && st_ff.bad_cnt == 2'h2 && mon_ok ##1 mon_ok |-> !FAILOVER_N_OUT)
    else $error("failover missing after three faults");

  // Third good kick releases failover
  chk_fail_release: assert property ( // RQ11
    good_ev && st_ff.good_cnt == 2'h2 && !FAILOVER_N_OUT |=> FAILOVER_N_OUT)
    else $error("failover not released after three good kicks");

  // No failover with comparator low
  chk_fail_mon_low: assert property ( // RQ13
    !mon_ok |=> FAILOVER_N_OUT)
    else $error("failover asserted with comparator low");

  // Enable rise starts an extended period
  chk_ext_start: assert property ( // RQ15
    en_rise |=> st_ff.extended && st_ff.wd_cnt == '0)
    else $error("extended period not started");

  // Kick ends the extended period
  chk_ext_kick: assert property ( // RQ16
    st_ff.extended && kick_ok && !en_rise |=> !st_ff.extended)
    else $error("extended period not ended by kick");

  // Extended period expiry asserts failover
  chk_ext_fail: assert property ( // RQ17
    late_ev && st_ff.extended && mon_ok ##1 mon_ok |-> !FAILOVER_N_OUT)
    else $error("failover missing after extended period");

  // Main scenarios
  cov_late_fault: cover property (late_ev ##1 !RESET_N_OUT);
  cov_early_fault: cover property (early_ev ##1 !RESET_N_OUT);
  cov_fail_set: cover property ($fell(FAILOVER_N_OUT));
  cov_fail_clear: cover property ($rose(FAILOVER_N_OUT));

endmodule // swf_top

// ==== sim/swf_mcu_model.sv ====
// Supervised processor model issuing periodic kick pulses
`timescale 1ns/1ps
module swf_mcu_model (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] per_in,
  output logic kick_out
);
  logic [7:0] cnt_ff;

  // Idle high before the first edge
  initial begin
    kick_out = 1'b1;
    cnt_ff = 8'h00;
  end

  // Cadence restarts when the processor leaves reset; zero means stuck
  always @(posedge clk_in) begin
    if (!rst_n_in || per_in == 8'h00) begin
      cnt_ff <= 8'h00;
      kick_out <= 1'b1;
    end else begin
      cnt_ff <= (cnt_ff == per_in - 8'h01) ? 8'h00 : cnt_ff + 8'h01;
      kick_out <= !(cnt_ff >= per_in - 8'h02);
    end
  end
endmodule // swf_mcu_model

// ==== sim/testbench.sv ====
// Self-checking bench for timeout, windowed and gated watchdogs
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %s expected %b seen %b", nm, exp, got); end end
module testbench;
  typedef struct packed {
    logic mon;
    logic [7:0] per;
    logic [15:0] n;
    logic low_t;
    logic fail_t;
    logic low_w;
    logic fail_w;
  } swf_row_s;

  logic clk, rstn, mon, en, seen_t, seen_w;
  logic [7:0] per;
  logic kick_t, kick_w, kick_g, rst_t, rst_w, rst_g;
  logic fail_t, fail_w, fail_g;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  swf_row_s rows [7];

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  swf_top #(.VARIANT(swf_pkg::SWF_TIMEOUT), .WDOG_PERIOD_CYC(40),
    .RESET_HOLD_CYC(8)) i_swf_top (.MCLK_IN(clk),
    .RSTN_IN(rstn), .KICK_IN(kick_t), .MONITOR_ABOVE_IN(mon),
    .ENABLE_CMP_IN(en), .RESET_N_OUT(rst_t), .FAILOVER_N_OUT(fail_t));
  swf_top #(.VARIANT(swf_pkg::SWF_WINDOWED), .WDOG_PERIOD_CYC(40),
    .RESET_HOLD_CYC(8)) i_swf_top_w (.MCLK_IN(clk),
    .RSTN_IN(rstn), .KICK_IN(kick_w), .MONITOR_ABOVE_IN(mon),
    .ENABLE_CMP_IN(en), .RESET_N_OUT(rst_w), .FAILOVER_N_OUT(fail_w));
  swf_top #(.VARIANT(swf_pkg::SWF_GATED),
    .WDOG_PERIOD_CYC(40)) i_swf_top_g (.MCLK_IN(clk),
    .RSTN_IN(rstn), .KICK_IN(kick_g), .MONITOR_ABOVE_IN(mon),
    .ENABLE_CMP_IN(en), .RESET_N_OUT(rst_g), .FAILOVER_N_OUT(fail_g));
  swf_mcu_model i_swf_mcu_model_t (.clk_in(clk), .rst_n_in(rst_t),
    .per_in(per), .kick_out(kick_t));
  swf_mcu_model i_swf_mcu_model_w (.clk_in(clk), .rst_n_in(rst_w),
    .per_in(per), .kick_out(kick_w));
  swf_mcu_model i_swf_mcu_model_g (.clk_in(clk), .rst_n_in(rst_g),
    .per_in(per), .kick_out(kick_g));

  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      summarize();
    end
  end

  // Rows: monitor, kick spacing, length, reset seen low and final flag
  initial begin
    rows = '{'{1'b1, 8'h1e, 16'h0096, 1'b0, 1'b1, 1'b0, 1'b1},
      '{1'b1, 8'h00, 16'h012c, 1'b1, 1'b0, 1'b1, 1'b0},
      '{1'b1, 8'h1e, 16'h012c, 1'b0, 1'b1, 1'b0, 1'b1},
      '{1'b1, 8'h0a, 16'h012c, 1'b0, 1'b1, 1'b1, 1'b0},
      '{1'b1, 8'h1e, 16'h012c, 1'b0, 1'b1, 1'b0, 1'b1},
      '{1'b0, 8'h00, 16'h012c, 1'b1, 1'b1, 1'b1, 1'b1},
      '{1'b1, 8'h1e, 16'h012c, 1'b0, 1'b1, 1'b0, 1'b1}};
    rstn = 1'b0;
    mon = 1'b1;
    en = 1'b1;
    per = 8'h00;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    // Table pass; reset activity is judged after a settling stretch
    for (int i = 0; i < 7; i++) begin
      mon <= rows[i].mon;
      per <= rows[i].per;
      seen_t = 1'b0;
      seen_w = 1'b0;
      for (int c = 0; c < int'(rows[i].n); c++) begin
        @(posedge clk);
        if (c >= 100 && rst_t !== 1'b1) seen_t = 1'b1;
        if (c >= 100 && rst_w !== 1'b1) seen_w = 1'b1;
      end
      `CHK("low_t", rows[i].low_t, seen_t)
      `CHK("fail_t", rows[i].fail_t, fail_t)
      `CHK("low_w", rows[i].low_w, seen_w)
      `CHK("fail_w", rows[i].fail_w, fail_w)
      $display("row %0d done", i);
    end
    // Gated: eightfold first period, then kicks recover the flag
    en <= 1'b0;
    per <= 8'h00;
    repeat (10) @(posedge clk);
    `CHK("fail_g", 1'b1, fail_g)
    en <= 1'b1;
    repeat (300) @(posedge clk);
    `CHK("fail_g", 1'b1, fail_g)
    repeat (40) @(posedge clk);
    `CHK("fail_g", 1'b0, fail_g)
    per <= 8'h1e;
    repeat (150) @(posedge clk);
    `CHK("fail_g", 1'b1, fail_g)
    $display("gated test done");
    // Mid-run reset, then hold after release
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("rst_t", 1'b0, rst_t)
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("rst_t", 1'b0, rst_t)
    repeat (10) @(posedge clk);
    `CHK("rst_t", 1'b1, rst_t)
    // Monitor dip, then hold period before release
    mon <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("rst_w", 1'b0, rst_w)
    mon <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("rst_w", 1'b0, rst_w)
    repeat (10) @(posedge clk);
    `CHK("rst_w", 1'b1, rst_w)
    $display("reset test done");
    summarize();
  end
endmodule // testbench
